// [common/otg_supply_pkg.sv]
// Purpose: Shared constants and carriers for the OTG supply control logic
// Assumes: 200 MHz ref_clk, synchronous active-high reset
// Notes:   Register offsets are word addresses on the plain register port
package otg_supply_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  // Register word addresses
  localparam logic [3:0]  OTG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  INT_RISE_ADDR   = 4'h1;
  localparam logic [3:0]  INT_FALL_ADDR   = 4'h2;
  localparam logic [3:0]  INT_STAT_ADDR   = 4'h3;
  localparam logic [3:0]  IO_PWR_ADDR     = 4'h4;
  localparam logic [3:0]  IND_CTRL_ADDR   = 4'h5;
  localparam logic [3:0]  RX_LAT_ADDR     = 4'h6;
  // OTG control fields
  localparam int          DRV_INT_POS     = 5;
  localparam int          DRV_EXT_POS     = 6;
  localparam int          DISCHARGE_POS   = 3;
  localparam int          CHARGE_POS      = 4;
  // Interrupt enable / status fields
  localparam int          SUPPLY_VLD_POS  = 1;
  localparam int          SESSION_VLD_POS = 2;
  // IO and power management fields
  localparam int          UART_MODE_POS   = 0;
  localparam int          DP_PULLUP_POS   = 1;
  localparam int          DM_PULLUP_POS   = 2;
  localparam int          UART_LVL_POS    = 3;
  localparam int          LVL_W           = 2;
  // Indicator control fields
  localparam int          USE_EXT_POS     = 0;
  localparam int          PASS_THRU_POS   = 1;
  localparam int          COMPLEMENT_POS  = 2;
  // Reset values
  localparam logic [7:0]  OTG_CTRL_RST    = 8'h00;
  localparam logic [7:0]  INT_EN_RST      = 8'h1f;
  localparam logic [7:0]  IO_PWR_RST      = 8'h00;
  localparam logic [7:0]  IND_CTRL_RST    = 8'h00;
  localparam logic [1:0]  USB_REG_LEVEL   = 2'h0;
  // Receive end latency in high-speed bit clocks
  localparam logic [7:0]  RX_END_LAT_MAX  = 8'h2b;
  localparam logic [7:0]  RX_END_LAT_SPEC = 8'h3f;
  localparam logic [7:0]  EXT_IND_LEVEL   = 8'h01;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  typedef struct packed {
    logic supply_valid;
    logic session_valid;
    logic [1:0] line_state;
  } analog_in_type;

  typedef struct packed {
    logic       pump_en;
    logic       discharge_en;
    logic       charge_en;
    logic       dp_pullup_en;
    logic       dm_pullup_en;
    logic       supply_cmp_en;
    logic       rx_supply_valid;
    logic [1:0] regulator_level;
    logic [1:0] line_state_out;
  } supply_out_type;

  typedef enum logic [0:0] {REG_ROUTE, TX_ROUTE} route_type;

endpackage

// [core/supply_valid_decode.sv]
// Purpose: Supply-valid source select for the receive command
// Assumes: Select bits come from a register
// Notes:   Pure combinational decode
`timescale 1ns/10ps
module supply_valid_decode
  import otg_supply_pkg::*;
(
  // Selects
  input  wire logic use_ext,
  input  wire logic pass_thru,
  input  wire logic complement,
  // Comparator
  input  wire logic internal_valid,
  // Result
  output logic      source_valid
);

  logic ext_indicator;

  assign ext_indicator = EXT_IND_LEVEL[0];

  always_comb begin
    if (!use_ext) begin
      source_valid = internal_valid;
    end else if (complement) begin
      source_valid = 1'b0;
    end else if (pass_thru) begin
      source_valid = ext_indicator;
    end else begin
      source_valid = internal_valid;
    end
  end

endmodule // supply_valid_decode

// [core/cmd_router.sv]
// Purpose: Single decoder steering link items to transmitter or registers
// Assumes: Register requests arrive on the plain port
// Notes:   Register requests pass straight through; transmit items become a registered pulse
`timescale 1ns/10ps
module cmd_router
  import otg_supply_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Link item
  input  wire logic        item_valid,
  input  wire logic        item_is_tx,
  input  wire reg_req_type item_req,
  // Routed outputs
  output reg_req_type      reg_req,
  output logic             tx_strobe
);

  typedef struct packed {
    logic tx;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  reg_req_type req_now;

  // one decoder, two destinations
  // Register path stays combinational so read data follow in one cycle
  always_comb begin
    state_next    = state_reg;
    state_next.tx = 1'b0;
    req_now       = item_req;
    req_now.wr    = 1'b0;
    req_now.rd    = 1'b0;
    if (item_valid) begin
      if (item_is_tx) begin
        state_next.tx = 1'b1;
      end else begin
        req_now = item_req;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_req   = req_now;
  assign tx_strobe = state_reg.tx;

endmodule // cmd_router

// [core/otg_supply_ctrl.sv]
// Purpose: OTG supply control and status registers with pin outputs
// Assumes: Comparator levels synchronous to ref_clk
// Notes:   Requests are steered without a register stage; read data follow in one cycle
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module otg_supply_ctrl
  import otg_supply_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic                tx_sel,
  output logic      [DATA_W-1:0]   rdata,
  output logic                     tx_strobe,
  // Analog side
  input  wire analog_in_type       analog_in,
  input  wire logic                reset_n_pin,
  // Control outputs
  output logic                     ext_pump_enable_out,
  output supply_out_type           supply_out
);

  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]     otg_ctrl;
    logic [7:0]     int_rise;
    logic [7:0]     int_fall;
    logic [7:0]     io_pwr;
    logic [7:0]     ind_ctrl;
    logic [7:0]     rdata;
    logic           pump;
    supply_out_type outs;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  reg_req_type req;
  reg_req_type link_req;
  logic        tx_pulse;
  logic        cmp_en;
  logic        src_valid;
  logic [7:0]  status;
  logic        uart_mode;

  assign link_req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  cmd_router u_router (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .item_valid(wr_en | rd_en),
    .item_is_tx(tx_sel),
    .item_req  (link_req),
    .reg_req   (req),
    .tx_strobe (tx_pulse)
  );

  supply_valid_decode u_decode (
    .use_ext       (state_reg.ind_ctrl[USE_EXT_POS]),
    .pass_thru     (state_reg.ind_ctrl[PASS_THRU_POS]),
    .complement    (state_reg.ind_ctrl[COMPLEMENT_POS]),
    .internal_valid(analog_in.supply_valid & cmp_en),
    .source_valid  (src_valid)
  );

  ////////////////////////////////////////////////////////////////////
  // comparator enable from both edge enables
  assign cmp_en    = state_reg.int_rise[SUPPLY_VLD_POS] | state_reg.int_fall[SUPPLY_VLD_POS];
  assign uart_mode = state_reg.io_pwr[UART_MODE_POS];

  // status bit reads zero when disabled
  always_comb begin
    status                  = 8'h00;
    status[SUPPLY_VLD_POS]  = analog_in.supply_valid & cmp_en;
    status[SESSION_VLD_POS] = analog_in.session_valid;
  end

  always_comb begin
    state_next = state_reg;
    if (req.wr) begin
      case (req.addr)
        OTG_CTRL_ADDR: state_next.otg_ctrl = req.wdata;
        INT_RISE_ADDR: state_next.int_rise = req.wdata;
        INT_FALL_ADDR: state_next.int_fall = req.wdata;
        IO_PWR_ADDR:   state_next.io_pwr   = req.wdata;
        IND_CTRL_ADDR: state_next.ind_ctrl = req.wdata & 8'h07;
        default:       state_next.otg_ctrl = state_reg.otg_ctrl;
      endcase
    end
    state_next.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OTG_CTRL_ADDR: state_next.rdata = state_reg.otg_ctrl;
        INT_RISE_ADDR: state_next.rdata = state_reg.int_rise;
        INT_FALL_ADDR: state_next.rdata = state_reg.int_fall;
        INT_STAT_ADDR: state_next.rdata = status;
        IO_PWR_ADDR:   state_next.rdata = state_reg.io_pwr;
        IND_CTRL_ADDR: state_next.rdata = state_reg.ind_ctrl;
        RX_LAT_ADDR:   state_next.rdata = RX_END_LAT_MAX;
        default:       state_next.rdata = 8'h00;
      endcase
    end
    state_next.pump = state_reg.otg_ctrl[DRV_INT_POS] | state_reg.otg_ctrl[DRV_EXT_POS];
    state_next.outs.pump_en = state_next.pump;
    state_next.outs.discharge_en = state_reg.otg_ctrl[DISCHARGE_POS];
    state_next.outs.charge_en = state_reg.otg_ctrl[CHARGE_POS];
    state_next.outs.dp_pullup_en = reset_n_pin & state_reg.io_pwr[DP_PULLUP_POS];
    state_next.outs.dm_pullup_en = reset_n_pin & state_reg.io_pwr[DM_PULLUP_POS];
    state_next.outs.supply_cmp_en = cmp_en;
    state_next.outs.rx_supply_valid = src_valid;
    state_next.outs.regulator_level = uart_mode ?
      state_reg.io_pwr[UART_LVL_POS +: LVL_W] : USB_REG_LEVEL;
    // line state withheld in UART mode
    state_next.outs.line_state_out = uart_mode ? 2'h0 : analog_in.line_state;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg.otg_ctrl <= OTG_CTRL_RST;
      state_reg.int_rise <= INT_EN_RST;
      state_reg.int_fall <= INT_EN_RST;
      state_reg.io_pwr   <= IO_PWR_RST;
      state_reg.ind_ctrl <= IND_CTRL_RST;
      state_reg.rdata    <= 8'h00;
      state_reg.pump     <= 1'b0;
      state_reg.outs     <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata               = state_reg.rdata;
  assign ext_pump_enable_out = state_reg.pump;
  assign supply_out          = state_reg.outs;
  assign tx_strobe           = tx_pulse;

  ////////////////////////////////////////////////////////////////////
  chk_pump_or_bits: assert property (@(posedge ref_clk) disable iff (rst)
    !rst |=> ext_pump_enable_out == ($past(state_reg.otg_ctrl[DRV_INT_POS])
      | $past(state_reg.otg_ctrl[DRV_EXT_POS])))
    else $error("pump enable not OR of drive bits");
  chk_pump_reset_low: assert property (@(posedge ref_clk)
    rst |=> !ext_pump_enable_out && !state_reg.otg_ctrl[DRV_INT_POS]
      && !state_reg.otg_ctrl[DRV_EXT_POS])
    else $error("pump enable set after reset");
  chk_status_zero_off: assert property (@(posedge ref_clk) disable iff (rst)
    rd_en && !tx_sel && addr == INT_STAT_ADDR && !state_reg.int_rise[SUPPLY_VLD_POS]
      && !state_reg.int_fall[SUPPLY_VLD_POS] |=> rdata[SUPPLY_VLD_POS] == 1'b0)
    else $error("status bit set while comparator off");
  chk_cmp_disable: assert property (@(posedge ref_clk) disable iff (rst)
    !rst |=> supply_out.supply_cmp_en == ($past(state_reg.int_rise[SUPPLY_VLD_POS])
      | $past(state_reg.int_fall[SUPPLY_VLD_POS])))
    else $error("comparator enable wrong");
  chk_complement_zero: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg.ind_ctrl[USE_EXT_POS] && state_reg.ind_ctrl[COMPLEMENT_POS]
      |=> !supply_out.rx_supply_valid)
    else $error("complement not forcing zero");
  chk_passthru_one: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg.ind_ctrl[2:0] == 3'h3 |=> supply_out.rx_supply_valid)
    else $error("pass-through not fixed one");
  chk_indicator_reset: assert property (@(posedge ref_clk)
    rst |=> state_reg.ind_ctrl == 8'h00)
    else $error("indicator select not cleared");
  chk_discharge_bit: assert property (@(posedge ref_clk) disable iff (rst)
    !rst |=> supply_out.discharge_en == $past(state_reg.otg_ctrl[DISCHARGE_POS]))
    else $error("discharge does not follow bit");
  chk_charge_bit: assert property (@(posedge ref_clk) disable iff (rst)
    !rst |=> supply_out.charge_en == $past(state_reg.otg_ctrl[CHARGE_POS]))
    else $error("charge does not follow bit");
  chk_pullup_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !reset_n_pin |=> !supply_out.dp_pullup_en && !supply_out.dm_pullup_en)
    else $error("pull-up on while reset pin low");
  chk_uart_level: assert property (@(posedge ref_clk) disable iff (rst)
    uart_mode |=> supply_out.regulator_level == $past(state_reg.io_pwr[UART_LVL_POS +: LVL_W]))
    else $error("regulator not retargeted");
  chk_uart_lines: assert property (@(posedge ref_clk) disable iff (rst)
    uart_mode |=> supply_out.line_state_out == 2'h0)
    else $error("line state shown in uart mode");
  chk_rx_latency: assert property (@(posedge ref_clk) disable iff (rst)
    rd_en && !tx_sel && addr == RX_LAT_ADDR |=> rdata <= 8'h2b && rdata < RX_END_LAT_SPEC)
    else $error("receive latency too large");
  chk_route_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && !tx_sel |-> req.wr ##1 !tx_pulse)
    else $error("write not routed to registers");
  chk_ind_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && !tx_sel && addr == IND_CTRL_ADDR |=> state_reg.ind_ctrl == ($past(wdata) & 8'h07))
    else $error("indicator select not written");

  cov_pump_on:   cover property (@(posedge ref_clk) ext_pump_enable_out);
  cov_uart_mode: cover property (@(posedge ref_clk) uart_mode);
  cov_fixed_one: cover property (@(posedge ref_clk) state_reg.ind_ctrl[2:0] == 3'h3);
  cov_cmp_off:   cover property (@(posedge ref_clk) !cmp_en);

endmodule // otg_supply_ctrl

// [tb/link_model.sv]
// Purpose: Link controller model driving the register port
// Assumes: Strobes sampled on rising ref_clk, read data in the following cycle only
// Notes:   Released address and data are inverted so stale values never look valid
`timescale 1ns/10ps
module link_model
  import otg_supply_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Register port
  input  wire logic [DATA_W-1:0] rdata,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr_en,
  output logic                   rd_en,
  output logic                   tx_sel
);
  initial begin
    addr   = 4'h0;
    wdata  = 8'h00;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    tx_sel = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // device owns bus timing
  // The model never drives read data and only answers on the device's schedule
  task automatic write_reg(input logic [3:0] a, input logic [7:0] v, input logic tx);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= v;
    wr_en  <= 1'b1;
    tx_sel <= tx;
    @(posedge ref_clk);
    wr_en  <= 1'b0;
    tx_sel <= 1'b0;
    addr   <= ~a;
    wdata  <= ~v;
  endtask

  // session over supply
  // Read status is returned raw; the model never starts work on supply valid
  task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    v = rdata;
  endtask
endmodule // link_model

// [tb/otg_vbus_control_logic_tb_top.sv]
// Purpose: Self-checking bench for the OTG supply control block
// Assumes: 200 MHz ref_clk, synchronous reset held 8 cycles
// Notes:   Expectations come from the register map, never from outputs
`timescale 1ns/10ps
module otg_vbus_control_logic_tb_top;
  import otg_supply_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst     = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic              tx_sel;
  logic [DATA_W-1:0] rdata;
  logic              tx_strobe;
  analog_in_type     analog_in;
  logic              reset_n_pin;
  logic              ext_pump_enable_out;
  supply_out_type    supply_out;
  logic              exp_v;
  int                fails  = 0;
  int                checks = 0;
  int                cycles = 0;
  int                seen;
  logic [7:0]        rst_val [8] = '{8'h00, 8'h1f, 8'h1f, 8'h02, 8'h00, 8'h00, 8'h2b, 8'h00};

  always #2.5 ref_clk = ~ref_clk;

  link_model u_link (
    .ref_clk (ref_clk),
    .rdata   (rdata),
    .addr    (addr),
    .wdata   (wdata),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .tx_sel  (tx_sel)
  );

  otg_supply_ctrl u_dut (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .addr                (addr),
    .wdata               (wdata),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .tx_sel              (tx_sel),
    .rdata               (rdata),
    .tx_strobe           (tx_strobe),
    .analog_in           (analog_in),
    .reset_n_pin         (reset_n_pin),
    .ext_pump_enable_out (ext_pump_enable_out),
    .supply_out          (supply_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    u_link.write_reg(a, v, 1'b0);
  endtask

  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_link.read_reg(a, v);
    chk(name, exp, v);
  endtask

  // Derived outputs land two cycles after the strobe; spare cycles follow
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Sequence needs about 790 cycles; a hang is cut well above that
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fails++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    analog_in = '0;
    analog_in.supply_valid = 1'b1;
    reset_n_pin = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk("pump after reset", 8'h00, 8'(ext_pump_enable_out));
    chk("rx after reset", 8'h01, 8'(supply_out.rx_supply_valid));
    foreach (rst_val[k]) rdchk("reset value", 4'(k), rst_val[k]);
    for (int i = 0; i < 16; i++) begin
      wr(OTG_CTRL_ADDR, 8'(i << 3));
      settle();
      chk("pump pin", 8'(i[2] | i[3]), 8'(ext_pump_enable_out));
      chk("pump field", 8'(i[2] | i[3]), 8'(supply_out.pump_en));
      chk("discharge", 8'(i[0]), 8'(supply_out.discharge_en));
      chk("charge", 8'(i[1]), 8'(supply_out.charge_en));
    end
    wr(OTG_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(IND_CTRL_ADDR, 8'(i & 7));
      @(posedge ref_clk);
      analog_in.supply_valid <= i[3];
      settle();
      exp_v = i[0] ? (i[2] ? 1'b0 : (i[1] ? 1'b1 : i[3])) : i[3];
      chk("rx supply", 8'(exp_v), 8'(supply_out.rx_supply_valid));
      rdchk("ind ctrl", IND_CTRL_ADDR, 8'(i & 7));
    end
    wr(IND_CTRL_ADDR, 8'h00);
    wr(INT_RISE_ADDR, 8'h1d);
    settle();
    chk("cmp on", 8'h01, 8'(supply_out.supply_cmp_en));
    rdchk("status", INT_STAT_ADDR, 8'h02);
    wr(INT_FALL_ADDR, 8'h1d);
    settle();
    chk("cmp off", 8'h00, 8'(supply_out.supply_cmp_en));
    chk("rx gated", 8'h00, 8'(supply_out.rx_supply_valid));
    rdchk("status", INT_STAT_ADDR, 8'h00);
    wr(INT_FALL_ADDR, 8'h02);
    settle();
    chk("cmp on", 8'h01, 8'(supply_out.supply_cmp_en));
    @(posedge ref_clk);
    analog_in.line_state <= 2'h2;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      reset_n_pin <= i[5];
      wr(IO_PWR_ADDR, 8'(i & 31));
      settle();
      chk("dp pullup", 8'(i[5] & i[1]), 8'(supply_out.dp_pullup_en));
      chk("dm pullup", 8'(i[5] & i[2]), 8'(supply_out.dm_pullup_en));
      chk("level", i[0] ? 8'(i[4:3]) : 8'(USB_REG_LEVEL), 8'(supply_out.regulator_level));
      chk("line", i[0] ? 8'h00 : 8'h02, 8'(supply_out.line_state_out));
    end
    wr(INT_STAT_ADDR, 8'hff);
    wr(RX_LAT_ADDR, 8'h00);
    wr(4'h7, 8'hff);
    analog_in.session_valid <= 1'b1;
    rdchk("status ro", INT_STAT_ADDR, 8'h06);
    rdchk("latency", RX_LAT_ADDR, 8'h2b);
    rdchk("unmapped", 4'h7, 8'h00);
    u_link.write_reg(OTG_CTRL_ADDR, 8'h20, 1'b1);
    seen = 0;
    repeat (4) begin
      #1;
      seen += int'(tx_strobe === 1'b1);
      @(posedge ref_clk);
    end
    chk("tx pulses", 8'h01, 8'(seen));
    chk("pump idle", 8'h00, 8'(ext_pump_enable_out));
    rdchk("ctrl kept", OTG_CTRL_ADDR, 8'h00);
    wr(OTG_CTRL_ADDR, 8'h40);
    wr(IND_CTRL_ADDR, 8'h05);
    settle();
    chk("pump ext only", 8'h01, 8'(ext_pump_enable_out));
    chk("rx fixed zero", 8'h00, 8'(supply_out.rx_supply_valid));
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk("pump after rerun", 8'h00, 8'(ext_pump_enable_out));
    chk("rx after rerun", 8'h01, 8'(supply_out.rx_supply_valid));
    rdchk("ind after rerun", IND_CTRL_ADDR, 8'h00);
    rdchk("ctrl after rerun", OTG_CTRL_ADDR, 8'h00);
    conclude();
  end
endmodule // otg_vbus_control_logic_tb_top
